// file: pwm_timer_waveform_tb_top.sv
// Purpose: self-checking bench for pwt_top
// Assumes: AXI4-Lite master tasks, pin load on the far side
// Notes: waveform phase found by search over one conversion period
`include "pwt_consts.vh"
module pwm_timer_waveform_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst, standby, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rs, bs;
   logic [15:0] pins_in, pins_out, pins_oe, ext;
   int num_errors, checks_done, cyc, c, i, pol, sel, dir, pa, pb;
   int duty[16];
   int ord[15] = '{15, 7, 11, 3, 13, 5, 9, 1, 14, 6, 10, 2, 12, 4, 8};
   pwt_top #(.CHANNELS(16)) i_dut (.clock(clock), .rst(rst), .standby(standby),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pwm_channel_pins_in(pins_in), .pwm_channel_pins_out(pins_out),
      .pwm_channel_pins_oe(pins_oe));
   pwt_pin_load #(.CHANNELS(16)) i_load (.pin_drive(pins_out), .pin_drive_en(pins_oe),
      .ext_level(ext), .pin_level(pins_in));
   // Clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Hang guard
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("Errors: %0d, checks: %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'b111;
      do begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clock);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      do begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // Expected pin levels for one counter value
   function automatic logic [15:0] exp_out(input int cnt);
      int u, l, k;
      logic a;
      for (int ch = 0; ch < 16; ch++) begin
         u = duty[ch] / 16;
         l = duty[ch] % 16;
         a = (u > 0) && (cnt % 16 >= 16 - u);
         for (k = 0; k < l; k++)
            if (ord[k] == cnt / 16 && cnt % 16 == 15 - u) a = 1'b1;
         a = a ^ pol[ch];
         exp_out[ch] = sel[ch] ? a : (ch < 8 ? pa[ch] : pb[ch - 8]);
      end
   endfunction
   // Capture a period of pins and search for the matching counter phase
   task automatic wave(input int d);
      logic [15:0] cap[512];
      logic [15:0] e[256];
      int k, t, hit;
      for (t = 0; t < 256; t++)
         e[t] = exp_out(t);
      repeat (4) @(posedge clock);
      for (t = 0; t < 256 * d; t++) begin
         @(posedge clock);
         cap[t] = pins_out;
      end
      hit = 0;
      for (k = 0; k < 256 * d; k++) begin
         c = 1;
         for (t = 0; t < 256 * d; t++)
            if (cap[t] !== e[(t + k) / d % 256]) c = 0;
         hit = hit + c;
      end
      chk(hit, 1);
   endtask
   // Main sequence
   initial begin
      {rst, standby, awvalid, wvalid, bready, arvalid, rready} = 7'b1000000;
      {awaddr, araddr, wdata, ext} = '0;
      void'($urandom(32'hf211));
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rd_reg(`PWT_ADDR_STC);
      chk(rd, `PWT_STC_RESET);
      rd_reg(`PWT_ADDR_DUTY_BASE + 8'h0c);
      chk(rd, `PWT_DUTY_RESET);
      rd_reg(8'h60);
      chk(rs, `PWT_RESP_SLVERR);
      for (i = 0; i < 16; i++) begin
         duty[i] = (i == 0) ? 'h0f : (i == 1) ? 'hff : (i == 2) ? 'hf1 : $urandom % 256;
         wr(8'(4 * i), duty[i]);
         rd_reg(8'(4 * i));
         chk(rd, duty[i]);
      end
      wr(8'h05, 'h5a);
      chk(bs, `PWT_RESP_SLVERR);
      rd_reg(8'h04);
      chk(rd, duty[1]);
      pol = $urandom % 65536;
      pa = $urandom % 256;
      pb = $urandom % 256;
      sel = 'hffff;
      wr(`PWT_ADDR_POLARITY, pol);
      chk(bs, `PWT_RESP_OKAY);
      wr(`PWT_ADDR_OUT_SEL, sel);
      wr(`PWT_ADDR_DIRECTION, 'hffff);
      wr(`PWT_ADDR_PORT_ONE, pa);
      wr(`PWT_ADDR_PORT_TWO, pb);
      wr(`PWT_ADDR_STC, 'h08);
      wave(1);
      wr(`PWT_ADDR_STC, 'h0c);
      wave(2);
      wr(`PWT_ADDR_STC, 'h00);
      rd_reg(`PWT_ADDR_COUNTER);
      i = rd;
      wr(`PWT_ADDR_COUNTER, 'h33);
      repeat (20) @(posedge clock);
      rd_reg(`PWT_ADDR_COUNTER);
      chk(rd, i);
      sel = $urandom % 65536;
      dir = $urandom % 65536;
      ext <= $urandom;
      wr(`PWT_ADDR_OUT_SEL, sel);
      wr(`PWT_ADDR_DIRECTION, dir);
      repeat (2) @(posedge clock);
      chk(pins_oe, dir[15:0]);
      chk(pins_out & dir[15:0], exp_out(i) & dir[15:0]);
      rd_reg(`PWT_ADDR_PIN_LEVEL);
      chk(rd, (exp_out(i) & dir[15:0]) | (ext & ~dir[15:0]));
      standby <= 1'b1;
      repeat (3) @(posedge clock);
      standby <= 1'b0;
      for (i = 0; i < 16; i++) begin
         rd_reg(8'(4 * i));
         chk(rd, `PWT_DUTY_RESET);
      end
      wrap_up();
   end
endmodule

// file: pwt_consts.vh
// Purpose: constants for the sixteen-channel PWM waveform generator
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes: byte addresses, field positions and reset values
`ifndef PWT_CONSTS_VH
`define PWT_CONSTS_VH

// Register byte addresses
`define PWT_ADDR_DUTY_BASE 8'h00
`define PWT_ADDR_DUTY_LAST 8'h3c
`define PWT_ADDR_POLARITY 8'h40
`define PWT_ADDR_OUT_SEL 8'h44
`define PWT_ADDR_DIRECTION 8'h48
`define PWT_ADDR_PORT_ONE 8'h4c
`define PWT_ADDR_PORT_TWO 8'h50
`define PWT_ADDR_STC 8'h54
`define PWT_ADDR_COUNTER 8'h58
`define PWT_ADDR_PIN_LEVEL 8'h5c

// Serial/timer control fields
`define PWT_STC_GATE_BIT 3
`define PWT_STC_CHOICE_BIT 2
`define PWT_STC_RESET 8'h00

// Reset values
`define PWT_DUTY_RESET 8'h00
`define PWT_CTRL16_RESET 16'h0000
`define PWT_PORT_RESET 8'h00
`define PWT_COUNTER_RESET 8'h00

// Waveform geometry
`define PWT_NIBBLE_FULL 5'h10
`define PWT_LAST_POS 4'hf

// AXI responses
`define PWT_RESP_OKAY 2'b00
`define PWT_RESP_SLVERR 2'b10
`endif

// file: pwt_duty_mem.v
// Purpose: storage of the sixteen duty data bytes
// Assumes: one write port, one registered read port, all bytes visible
// Notes: standby clear empties every byte at once
`include "pwt_consts.vh"

module pwt_duty_mem #(
   parameter CHANNELS = 16,
   parameter AW = 4
) (
   input wire clock,
   input wire rst,
   input wire clear,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [7:0] wdata,
   input wire re,
   input wire [AW-1:0] raddr,
   output reg [7:0] rdata,
   output wire [CHANNELS*8-1:0] all_bytes
);
   reg [7:0] mem_r [0:CHANNELS-1];
   integer i;
   genvar g;

   // Byte array, cleared at reset and in standby
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         for (i = 0; i < CHANNELS; i = i + 1) begin
            mem_r[i] <= `PWT_DUTY_RESET;
         end
      end else if (clear) begin
         for (i = 0; i < CHANNELS; i = i + 1) begin
            mem_r[i] <= `PWT_DUTY_RESET;
         end
      end else if (we) begin
         mem_r[waddr] <= wdata;
      end
   end

   // Registered read port for the bus
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= `PWT_DUTY_RESET;
      end else if (re) begin
         rdata <= mem_r[raddr];
      end
   end

   // Parallel view for the waveform logic
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : gen_flat
         assign all_bytes[g*8 +: 8] = mem_r[g];
      end
   endgenerate
endmodule

// file: pwt_monitor.sv
// Purpose: bus and pin timing checks
// Assumes: one clock, async high reset
// Notes: bound to pwt_top at the foot
module pwt_monitor #(
   parameter CHANNELS = 16
) (
   input wire clock,
   input wire rst,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [CHANNELS-1:0] pwm_channel_pins_out,
   input wire [CHANNELS-1:0] pwm_channel_pins_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Register bus answers and holds
   property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid; endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("late write answer");
   property p_rd_ans; s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer off");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_aw_drop; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
   a_aw_drop: assert property (p_aw_drop) else $error("second write taken");
   property p_ar_back; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready; endproperty
   a_ar_back: assert property (p_ar_back) else $error("read not re-armed");
   // Pin drive enable only moves with a register write
   property p_oe_write; $changed(pwm_channel_pins_oe)
      |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
   a_oe_write: assert property (p_oe_write) else $error("pin enable moved alone");
   property p_idle; $fell(rst) |-> (pwm_channel_pins_oe == 0 && pwm_channel_pins_out == 0)[*3];
   endproperty
   a_idle: assert property (p_idle) else $error("pins busy after reset");
endmodule

bind pwt_top pwt_monitor #(.CHANNELS(CHANNELS)) i_mon (
   .clock(clock), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .pwm_channel_pins_out(pwm_channel_pins_out),
   .pwm_channel_pins_oe(pwm_channel_pins_oe));

// file: pwt_pin_load.sv
// Purpose: loads on the channel pins
// Assumes: far side drives its own level where the block does not
// Notes: undriven pins never echo the last driven value
module pwt_pin_load #(
   parameter CHANNELS = 16
) (
   input wire [CHANNELS-1:0] pin_drive,
   input wire [CHANNELS-1:0] pin_drive_en,
   input wire [CHANNELS-1:0] ext_level,
   output wire [CHANNELS-1:0] pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Driven pins carry the block level, others the outside level
   assign pin_level = (pin_drive & pin_drive_en) | (ext_level & ~pin_drive_en);
endmodule

// file: pwt_top.v
// Purpose: sixteen-channel 8-bit PWM waveform generator with AXI4-Lite registers
// Assumes: peripheral clock equals the system clock; pins synchronous
// Notes: pin output and enable come from flip-flops; one write, one read at a time
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`include "pwt_consts.vh"

// Summary of operation
// - A pin routed to port output is driven by its port data bit.
// - The serial/timer control register resets to all zeros.
// - Clock gate clear stops the counter; choice 0 ticks every clock, 1 every second clock.
// - One resolution unit is one counter tick and a conversion period is 256 units.
// - The conversion period splits into 16 equal basic pulses.
// - The upper duty nibble sets each basic pulse's active width in sixteenths.
// - An extra pulse is one unit wide, directly before the basic pulse's rising edge.
// - With upper nibble zero, extra pulses still land in the same time slots.
// - Lower nibble values 1 to 6 add pulses 15, 7, 11, 3, 13, 5 cumulatively.
// - Value 8 covers all odd pulses; 9 to 12 add 14, 6, 10, 2 cumulatively.
// - Polarity bit 0 gives direct output, 1 gives inverted output.
// - Direction 0 makes a pin an input; direction 1 gives port or PWM output.
// - Duty bytes clear on reset and in standby.
module pwt_top #(
   parameter CHANNELS = 16
) (
   input wire clock,
   input wire rst,
   input wire standby,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [CHANNELS-1:0] pwm_channel_pins_in,
   output reg [CHANNELS-1:0] pwm_channel_pins_out,
   output reg [CHANNELS-1:0] pwm_channel_pins_oe
);
   // Rank of a slot is its inverted index bit-reversed; slot gets an extra pulse when lower nibble exceeds it
   function [3:0] pwt_rank;
      input [3:0] slot;
      reg [3:0] inv;
      begin
         inv = ~slot;
         pwt_rank = {inv[0], inv[1], inv[2], inv[3]};
      end
   endfunction

   // Active level of one channel at a counter value, before polarity
   function pwt_active;
      input [7:0] duty;
      input [7:0] cnt;
      reg [4:0] sum;
      reg basic;
      reg extra;
      begin
         sum = {1'b0, cnt[3:0]} + {1'b0, duty[7:4]};
         basic = (sum >= `PWT_NIBBLE_FULL);
         extra = (cnt[3:0] == (`PWT_LAST_POS - duty[7:4])) &&
                 (duty[3:0] > pwt_rank(cnt[7:4]));
         pwt_active = basic | extra;
      end
   endfunction

   // Word address helpers
   function is_duty;
      input [7:0] a;
      begin
         is_duty = (a <= `PWT_ADDR_DUTY_LAST);
      end
   endfunction

   // Word address that the register map decodes
   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = is_duty(a) ||
                     a == `PWT_ADDR_POLARITY || a == `PWT_ADDR_OUT_SEL ||
                     a == `PWT_ADDR_DIRECTION || a == `PWT_ADDR_PORT_ONE ||
                     a == `PWT_ADDR_PORT_TWO || a == `PWT_ADDR_STC ||
                     a == `PWT_ADDR_COUNTER || a == `PWT_ADDR_PIN_LEVEL;
      end
   endfunction

   // Two-lane byte merge for the 16-bit control registers
   function [15:0] pwt_merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         pwt_merge16 = old;
         if (strb[0]) pwt_merge16[7:0] = data[7:0];
         if (strb[1]) pwt_merge16[15:8] = data[15:8];
      end
   endfunction

   // Control registers
   reg [15:0] polarity_invert_r;
   reg [15:0] out_select_r;
   reg [15:0] direction_r;
   reg [7:0] pin_level_port_one_r;
   reg [7:0] pin_level_port_two_r;
   reg [7:0] serial_timer_control_r;
   reg [7:0] pwm_counter_r;
   reg half_rate_r;

   // Bus state
   reg aw_have_r;
   reg w_have_r;
   reg [7:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg rd_pend_r;
   reg [7:0] ar_addr_r;

   // Clock selection, bus strobes and duty memory nets
   wire pwm_clock_gate;
   wire pwm_clock_choice;
   wire tick;
   wire do_write;
   wire ar_take;
   wire mem_we;
   wire [7:0] duty_rdata;
   wire [CHANNELS*8-1:0] duty_all;
   reg [31:0] rd_word;
   reg rd_ok;
   reg wr_ok;
   reg [CHANNELS-1:0] pin_nxt;
   integer c;

   assign pwm_clock_gate = serial_timer_control_r[`PWT_STC_GATE_BIT];
   assign pwm_clock_choice = serial_timer_control_r[`PWT_STC_CHOICE_BIT];
   // Counter tick: none when gated, every clock or every second clock
   assign tick = pwm_clock_gate & (~pwm_clock_choice | half_rate_r);
   // Write fires once address and data are both held and no answer waits
   assign do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
   assign ar_take = s_axi_arvalid & s_axi_arready;
   // Duty bytes take only mapped, aligned lane-0 writes
   assign mem_we = do_write & wr_ok & is_duty(aw_addr_r) & w_strb_r[0];

   // Duty byte storage; read port addressed straight from the bus
   pwt_duty_mem #(
      .CHANNELS(CHANNELS),
      .AW(4)
   ) u_duty (
      .clock(clock),
      .rst(rst),
      .clear(standby),
      .we(mem_we),
      .waddr(aw_addr_r[5:2]),
      .wdata(w_data_r[7:0]),
      .re(ar_take),
      .raddr(s_axi_araddr[5:2]),
      .rdata(duty_rdata),
      .all_bytes(duty_all)
   );

   // Divide-by-two enable for the peripheral clock choice
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         half_rate_r <= 1'b0;
      end else begin
         half_rate_r <= ~half_rate_r;
      end
   end

   // 8-bit counter: one unit per tick, 256 units per period
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         pwm_counter_r <= `PWT_COUNTER_RESET;
      end else if (tick) begin
         pwm_counter_r <= pwm_counter_r + 8'h01;
      end
   end

   // Per-channel pin level and enable
   always @* begin
      for (c = 0; c < CHANNELS; c = c + 1) begin
         if (out_select_r[c]) begin
            pin_nxt[c] = pwt_active(duty_all[c*8 +: 8], pwm_counter_r) ^
                         polarity_invert_r[c];
         end else if (c < 8) begin
            pin_nxt[c] = pin_level_port_one_r[c % 8];
         end else begin
            pin_nxt[c] = pin_level_port_two_r[c % 8];
         end
      end
   end

   // Pin flops; direction 0 releases the pin as an input
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         pwm_channel_pins_out <= {CHANNELS{1'b0}};
         pwm_channel_pins_oe <= {CHANNELS{1'b0}};
      end else begin
         pwm_channel_pins_out <= pin_nxt;
         pwm_channel_pins_oe <= direction_r[CHANNELS-1:0];
      end
   end

   // Write address and data channels, taken in either order
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (do_write) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (do_write) begin
            w_have_r <= 1'b0;
         end
      end
   end

   // Address decode for writes
   always @* begin
      wr_ok = 1'b1;
      if (!is_mapped(aw_addr_r)) begin
         wr_ok = 1'b0;
      end
      if (aw_addr_r[1:0] != 2'b00) begin
         wr_ok = 1'b0;
      end
   end

   // Register writes and write response
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         polarity_invert_r <= `PWT_CTRL16_RESET;
         out_select_r <= `PWT_CTRL16_RESET;
         direction_r <= `PWT_CTRL16_RESET;
         pin_level_port_one_r <= `PWT_PORT_RESET;
         pin_level_port_two_r <= `PWT_PORT_RESET;
         serial_timer_control_r <= `PWT_STC_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PWT_RESP_OKAY;
      end else begin
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `PWT_RESP_OKAY : `PWT_RESP_SLVERR;
            case (aw_addr_r)
               `PWT_ADDR_POLARITY: begin
                  polarity_invert_r <= pwt_merge16(polarity_invert_r, w_data_r, w_strb_r);
               end
               `PWT_ADDR_OUT_SEL: begin
                  out_select_r <= pwt_merge16(out_select_r, w_data_r, w_strb_r);
               end
               `PWT_ADDR_DIRECTION: begin
                  direction_r <= pwt_merge16(direction_r, w_data_r, w_strb_r);
               end
               `PWT_ADDR_PORT_ONE: begin
                  if (w_strb_r[0]) pin_level_port_one_r <= w_data_r[7:0];
               end
               `PWT_ADDR_PORT_TWO: begin
                  if (w_strb_r[0]) pin_level_port_two_r <= w_data_r[7:0];
               end
               `PWT_ADDR_STC: begin
                  if (w_strb_r[0]) serial_timer_control_r <= w_data_r[7:0];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Read data selection for duty bytes and the other registers
   always @* begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      if (is_duty(ar_addr_r)) begin
         rd_word = {24'h000000, duty_rdata};
      end else begin
         case (ar_addr_r)
            `PWT_ADDR_POLARITY: rd_word = {16'h0000, polarity_invert_r};
            `PWT_ADDR_OUT_SEL: rd_word = {16'h0000, out_select_r};
            `PWT_ADDR_DIRECTION: rd_word = {16'h0000, direction_r};
            `PWT_ADDR_PORT_ONE: rd_word = {24'h000000, pin_level_port_one_r};
            `PWT_ADDR_PORT_TWO: rd_word = {24'h000000, pin_level_port_two_r};
            `PWT_ADDR_STC: rd_word = {24'h000000, serial_timer_control_r};
            `PWT_ADDR_COUNTER: rd_word = {24'h000000, pwm_counter_r};
            `PWT_ADDR_PIN_LEVEL: rd_word = {16'h0000, pwm_channel_pins_in};
            default: rd_ok = 1'b0;
         endcase
      end
      if (ar_addr_r[1:0] != 2'b00) begin
         rd_ok = 1'b0;
         rd_word = 32'h00000000;
      end
   end

   // Read channel: address taken, data one cycle later from the duty memory
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         rd_pend_r <= 1'b0;
         ar_addr_r <= 8'h00;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PWT_RESP_OKAY;
      end else begin
         s_axi_arready <= ~ar_take & ~rd_pend_r & ~s_axi_rvalid;
         if (ar_take) begin
            rd_pend_r <= 1'b1;
            ar_addr_r <= s_axi_araddr;
         end
         if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `PWT_RESP_OKAY : `PWT_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
